// File: rtl/epg_pkg.sv
package epg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and pulse timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CF_NOM_MS = 90;
  localparam int CF_NOM_CYC = CF_NOM_MS * CYC_PER_MS;
  localparam int CF_HALF_MS = 180;
  localparam int CF_HALF_CYC = CF_HALF_MS * CYC_PER_MS;
  localparam int LF_HALF_MS = 240;
  localparam int LF_HALF_CYC = LF_HALF_MS * CYC_PER_MS;
  localparam int LF_NOM_MS = 120;
  localparam int LF_NOM_CYC = LF_NOM_MS * CYC_PER_MS;
  localparam int CF_HF_US = 35;
  localparam int CF_HF_CYC = (CF_HF_US * CLK_HZ + 999_999) / 1_000_000;

  ////////////////////////////////////////////////////////////////////////////
  // energy accumulation
  localparam int PWR_W = 24;
  localparam int ACC_W = 32;
  localparam int TIM_W = 32;
  localparam logic [ACC_W-1:0] LF_QUANTUM = 32'h0800_0000;
  localparam logic [PWR_W:0] NOLOAD_THRESH = 25'h000_0100;
  localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
  localparam logic [11:0] CF_CNT_RST = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] MASK_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] STATE_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] COUNT_OFS = 4'hc;
  localparam int ST_W = 3;
  localparam int ST_CF_BIT = 0;
  localparam int ST_LF_BIT = 1;
  localparam int ST_REV_BIT = 2;
  localparam logic [ST_W-1:0] STATUS_RST = 3'h0;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam int STATE_REV_BIT = 0;
  localparam int STATE_SIDE_BIT = 1;
  localparam int STATE_HF_BIT = 2;
  localparam int STATE_RATE_POS = 4;
  localparam int STATE_SCALE_BIT = 6;

  typedef struct packed {
    logic scale;
    logic [1:0] rate;
  } epg_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } epg_bus_t;

  // log2 of calibration-to-low-frequency pulse ratio
  function automatic logic [3:0] epg_mult_log2(input epg_cfg_t cfg);
    logic [3:0] r;
    r = 4'h0;
    if (cfg.scale) begin
      r = 4'h7 - {2'b00, cfg.rate};
    end else if (cfg.rate == 2'b11) begin
      r = 4'hb;
    end else begin
      r = 4'h6 - {2'b00, cfg.rate};
    end
    return r;
  endfunction

  function automatic logic epg_hf_mode(input epg_cfg_t cfg);
    return !cfg.scale && (cfg.rate == 2'b11);
  endfunction

endpackage

// File: rtl/epg_pulse_shaper.sv
`timescale 1ns/100ps
`default_nettype none

module epg_pulse_shaper (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // pulse request and width control
  input wire logic trig_i,
  input wire logic fixed_en_i,
  input wire logic [epg_pkg::TIM_W-1:0] fixed_cyc_i,
  input wire logic [epg_pkg::TIM_W-1:0] nom_cyc_i,
  input wire logic [epg_pkg::TIM_W-1:0] half_limit_i,
  // shaped pulse, active high
  output logic pulse_o
);
  import epg_pkg::*;

  logic [TIM_W-1:0] period_reg, period_next;
  logic [TIM_W-1:0] width_reg, width_next;
  logic [TIM_W-1:0] width_sel;
  logic active_reg, active_next;
  logic seen_reg, seen_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    period_next = (period_reg == '1) ? period_reg : period_reg + 1'b1;
    width_next = width_reg;
    active_next = active_reg;
    seen_next = seen_reg;
    width_sel = nom_cyc_i;
    if (fixed_en_i) begin
      width_sel = fixed_cyc_i;
    end else if (seen_reg && period_reg < half_limit_i) begin
      width_sel = (period_reg >> 1);
    end
    if (width_sel == '0) begin
      width_sel = {{(TIM_W-1){1'b0}}, 1'b1};
    end
    if (trig_i) begin
      period_next = {{(TIM_W-1){1'b0}}, 1'b1};
      width_next = width_sel - 1'b1;
      active_next = 1'b1;
      seen_next = 1'b1;
    end else if (active_reg) begin
      if (width_reg == '0) begin
        active_next = 1'b0;
      end else begin
        width_next = width_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      period_reg <= '0;
      width_reg <= '0;
      active_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      period_reg <= period_next;
      width_reg <= width_next;
      active_reg <= active_next;
      seen_reg <= seen_next;
    end
  end

  assign pulse_o = active_reg;

  ////////////////////////////////////////////////////////////////////////////
  a_short_half: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    trig_i && !fixed_en_i && seen_reg && period_reg < half_limit_i && period_reg > 3
    |=> width_reg == ($past(period_reg) >> 1) - 1)
    else $error("short period pulse not half period");

endmodule

`default_nettype wire

// File: rtl/epg_pulse_gen.sv
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module epg_pulse_gen #(
  parameter int CF_NOM_CYC = epg_pkg::CF_NOM_CYC,
  parameter int CF_HALF_CYC = epg_pkg::CF_HALF_CYC,
  parameter int LF_NOM_CYC = epg_pkg::LF_NOM_CYC,
  parameter int LF_HALF_CYC = epg_pkg::LF_HALF_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // power samples from the front end
  input wire logic signed [epg_pkg::PWR_W-1:0] power_i,
  input wire logic power_vld_i,
  // rate and scale selection pins
  input wire logic rate_sel_lo_i,
  input wire logic rate_sel_hi_i,
  input wire logic calib_scale_sel_i,
  // register port
  input wire epg_pkg::epg_bus_t bus_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  // metering outputs
  output logic lowfreq_pulse_a_o,
  output logic lowfreq_pulse_b_o,
  output logic calib_pulse_out_o,
  output logic reverse_power_flag_o
);
  import epg_pkg::*;

  epg_cfg_t cfg;
  logic hf_mode;
  logic [3:0] mult_log2;
  logic [11:0] mult_m1;
  logic [ACC_W-1:0] cf_thresh;
  logic [PWR_W:0] mag;
  logic accept;
  logic [ACC_W-1:0] addend;
  logic [ACC_W:0] sum;
  logic cf_evt, cf_fire, lf_fire, rev_evt;

  logic [ACC_W-1:0] acc_reg, acc_next;
  logic [11:0] cf_cnt_reg, cf_cnt_next;
  logic rev_reg, rev_next;
  logic side_reg, side_next;
  logic cur_side_reg, cur_side_next;
  logic lf_a_reg, lf_a_next;
  logic lf_b_reg, lf_b_next;
  logic lf_active, cf_active;

  logic [ST_W-1:0] status_reg, status_next;
  logic [ST_W-1:0] mask_reg, mask_next;
  logic [15:0] count_reg, count_next;
  logic [31:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode
  always_comb begin
    cfg.scale = calib_scale_sel_i;
    cfg.rate = {rate_sel_hi_i, rate_sel_lo_i};
    hf_mode = epg_hf_mode(cfg);
    mult_log2 = epg_mult_log2(cfg);
    mult_m1 = 12'((32'h1 << mult_log2) - 32'h1);
    cf_thresh = LF_QUANTUM >> mult_log2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // energy accumulation and pulse instants
  always_comb begin
    mag = power_i[PWR_W-1] ? -{power_i[PWR_W-1], power_i} : {1'b0, power_i};
    accept = power_vld_i && (mag >= NOLOAD_THRESH);
    addend = ACC_W'({7'h00, mag} << cfg.rate);
    sum = {1'b0, acc_reg} + {1'b0, addend};
    acc_next = acc_reg;
    cf_evt = 1'b0;
    if (accept) begin
      if (sum >= {1'b0, cf_thresh}) begin
        cf_evt = 1'b1;
        acc_next = ACC_W'(sum - {1'b0, cf_thresh});
      end else begin
        acc_next = sum[ACC_W-1:0];
      end
    end
    // sign of the sample is the quadrant test of the two channels
    cf_fire = cf_evt && !power_i[PWR_W-1];
    rev_next = cf_evt ? power_i[PWR_W-1] : rev_reg;
    rev_evt = cf_evt && (power_i[PWR_W-1] != rev_reg);
    cf_cnt_next = cf_cnt_reg;
    lf_fire = 1'b0;
    if (cf_fire) begin
      if (cf_cnt_reg >= mult_m1) begin
        cf_cnt_next = CF_CNT_RST;
        lf_fire = 1'b1;
      end else begin
        cf_cnt_next = cf_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_reg <= ACC_RST;
      cf_cnt_reg <= CF_CNT_RST;
      rev_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      cf_cnt_reg <= cf_cnt_next;
      rev_reg <= rev_next;
    end
  end

  assign reverse_power_flag_o = rev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // pulse shaping
  epg_pulse_shaper u_cf_shaper (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .trig_i(cf_fire),
    .fixed_en_i(hf_mode),
    .fixed_cyc_i(TIM_W'(CF_HF_CYC)),
    .nom_cyc_i(TIM_W'(CF_NOM_CYC)),
    .half_limit_i(TIM_W'(CF_HALF_CYC)),
    .pulse_o(cf_active)
  );

  epg_pulse_shaper u_lf_shaper (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .trig_i(lf_fire),
    .fixed_en_i(1'b0),
    .fixed_cyc_i(TIM_W'(LF_NOM_CYC)),
    .nom_cyc_i(TIM_W'(LF_NOM_CYC)),
    .half_limit_i(TIM_W'(LF_HALF_CYC)),
    .pulse_o(lf_active)
  );

  assign calib_pulse_out_o = cf_active;

  ////////////////////////////////////////////////////////////////////////////
  // alternating low-frequency outputs
  always_comb begin
    side_next = lf_fire ? !side_reg : side_reg;
    cur_side_next = lf_fire ? side_reg : cur_side_reg;
    lf_a_next = !(lf_active && !cur_side_reg);
    lf_b_next = !(lf_active && cur_side_reg);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      side_reg <= 1'b0;
      cur_side_reg <= 1'b0;
      lf_a_reg <= 1'b1;
      lf_b_reg <= 1'b1;
    end else begin
      side_reg <= side_next;
      cur_side_reg <= cur_side_next;
      lf_a_reg <= lf_a_next;
      lf_b_reg <= lf_b_next;
    end
  end

  assign lowfreq_pulse_a_o = lf_a_reg;
  assign lowfreq_pulse_b_o = lf_b_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register port and interrupt
  always_comb begin
    logic [ST_W-1:0] clr;
    logic [ST_W-1:0] set;
    clr = '0;
    set = '0;
    set[ST_CF_BIT] = cf_fire;
    set[ST_LF_BIT] = lf_fire;
    set[ST_REV_BIT] = rev_evt;
    if (bus_i.wr && bus_i.addr == STATUS_OFS) begin
      clr = bus_i.wdata[ST_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    status_next = (status_reg & ~clr) | set;
    mask_next = mask_reg;
    if (bus_i.wr && bus_i.addr == MASK_OFS) begin
      mask_next = bus_i.wdata[ST_W-1:0];
    end
    count_next = lf_fire ? count_reg + 1'b1 : count_reg;
    if (bus_i.wr && bus_i.addr == COUNT_OFS) begin
      count_next = bus_i.wdata[15:0];
    end
    rdata_next = 32'h0000_0000;
    if (bus_i.rd) begin
      case (bus_i.addr)
        STATUS_OFS: rdata_next[ST_W-1:0] = status_reg;
        MASK_OFS: rdata_next[ST_W-1:0] = mask_reg;
        STATE_OFS: begin
          rdata_next[STATE_REV_BIT] = rev_reg;
          rdata_next[STATE_SIDE_BIT] = side_reg;
          rdata_next[STATE_HF_BIT] = hf_mode;
          rdata_next[STATE_RATE_POS +: 2] = cfg.rate;
          rdata_next[STATE_SCALE_BIT] = cfg.scale;
        end
        COUNT_OFS: rdata_next[15:0] = count_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_reg <= STATUS_RST;
      mask_reg <= MASK_RST;
      count_reg <= COUNT_RST;
      rdata_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      count_reg <= count_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [TIM_W-1:0] cf_hi_cnt_reg;
  logic hf_hold_reg;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cf_hi_cnt_reg <= '0;
      hf_hold_reg <= 1'b0;
    end else begin
      // a retrigger restarts the width count, as it restarts the pulse
      cf_hi_cnt_reg <= (calib_pulse_out_o && !cf_fire) ? cf_hi_cnt_reg + 1'b1 : '0;
      hf_hold_reg <= cf_fire ? hf_mode : hf_hold_reg;
    end
  end

  a_lf_never_both: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lowfreq_pulse_a_o || lowfreq_pulse_b_o)
    else $error("both low outputs active together");

  a_lf_side_flip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lf_fire |=> side_reg != $past(side_reg) && cur_side_reg == $past(side_reg))
    else $error("low outputs did not alternate");

  a_lf_active_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lf_active && !cur_side_reg |=> !lowfreq_pulse_a_o && lowfreq_pulse_b_o)
    else $error("low output a not driven low");

  a_cf_hf_width: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(calib_pulse_out_o) && hf_hold_reg |-> cf_hi_cnt_reg == TIM_W'(CF_HF_CYC))
    else $error("high-frequency calibration width wrong");

  a_cf_nom_width: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(calib_pulse_out_o) && !hf_hold_reg |-> cf_hi_cnt_reg <= TIM_W'(CF_NOM_CYC))
    else $error("calibration pulse wider than nominal");

  a_cf_rise: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cf_fire |=> calib_pulse_out_o)
    else $error("calibration pulse not issued");

  a_rev_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !cf_evt |=> $stable(reverse_power_flag_o))
    else $error("reverse flag changed between pulses");

  a_rev_sign: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cf_evt |=> reverse_power_flag_o == $past(power_i[PWR_W-1]))
    else $error("reverse flag does not follow power sign");

  a_noload_block: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !accept |-> !cf_fire && !lf_fire ##1 acc_reg == $past(acc_reg))
    else $error("sub-threshold power produced energy");

  a_rate_scale: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    accept && !cf_evt |=> acc_reg - $past(acc_reg) ==
      ($past(power_i < 0 ? -32'(power_i) : 32'(power_i)) << $past({rate_sel_hi_i, rate_sel_lo_i})))
    else $error("accumulation not scaled by rate code");

  a_lf_ratio: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lf_fire |-> cf_fire && cf_cnt_reg == mult_m1)
    else $error("low pulse not at calibration multiple");

  c_cf_pulse: cover property (@(posedge clk_i) disable iff (sys_rst_i) cf_fire);
  c_lf_pulse: cover property (@(posedge clk_i) disable iff (sys_rst_i) lf_fire && side_reg);
  c_rev_rise: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(reverse_power_flag_o));
  c_hf_pulse: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(calib_pulse_out_o) && hf_hold_reg);

endmodule

`default_nettype wire

// File: verification/epg_meter_model.sv
`timescale 1ns/100ps
`default_nettype none

module epg_meter_model (
  // clock and clear
  input wire logic clk_i,
  input wire logic clr_i,
  // metering pulses from the block
  input wire logic lf_a_i,
  input wire logic lf_b_i,
  input wire logic cf_i,
  // tallies and last pulse widths in cycles
  output var int n_a_o,
  output var int n_b_o,
  output var int n_cf_o,
  output var int lf_w_o,
  output var int cf_w_o,
  output var int n_bad_o
);
  logic lf_q;
  logic cf_q;
  logic nxt_b;
  int lw;
  int cw;

  ////////////////////////////////////////////////////////////////////////
  // two-phase counter coil: steps a then b, counts out-of-turn steps
  always @(posedge clk_i) begin
    if (clr_i) begin
      {n_a_o, n_b_o, n_cf_o, n_bad_o, lf_w_o, cf_w_o} <= 192'h0;
      {lf_q, cf_q, nxt_b} <= 3'b000;
      lw <= 0;
      cw <= 0;
    end else begin
      lf_q <= !(lf_a_i && lf_b_i);
      cf_q <= cf_i;
      if (!lf_a_i || !lf_b_i) begin
        lw <= lw + 1;
      end else if (lf_q) begin
        lf_w_o <= lw;
        lw <= 0;
      end
      if (!lf_q && !lf_a_i) begin
        n_a_o <= n_a_o + 1;
        nxt_b <= 1'b1;
        n_bad_o <= n_bad_o + int'(nxt_b || !lf_b_i);
      end else if (!lf_q && !lf_b_i) begin
        n_b_o <= n_b_o + 1;
        nxt_b <= 1'b0;
        n_bad_o <= n_bad_o + int'(!nxt_b);
      end
      if (cf_i) begin
        cw <= cw + 1;
      end else if (cf_q) begin
        cf_w_o <= cw;
        cw <= 0;
      end
      if (cf_i && !cf_q) begin
        n_cf_o <= n_cf_o + 1;
      end
    end
  end

endmodule

`default_nettype wire

// File: verification/tb_epg_pulse_gen.sv
`timescale 1ns/100ps
`default_nettype none

module tb_epg_pulse_gen;
  import epg_pkg::*;
  localparam int CFN = 40;
  localparam int LFN = 60;
  localparam int MULT [8] = '{128, 64, 32, 16, 64, 32, 16, 2048};
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic signed [PWR_W-1:0] power_i = '0;
  logic power_vld_i = 1'b0;
  logic rate_sel_lo_i = 1'b0;
  logic rate_sel_hi_i = 1'b0;
  logic calib_scale_sel_i = 1'b1;
  epg_bus_t bus_i = '0;
  logic [31:0] rdata_o;
  logic irq;
  logic lf_a;
  logic lf_b;
  logic cf;
  logic rev;
  int n_a, n_b, n_cf, lf_w, cf_w, n_bad;
  int n_errors = 0;
  int num_checks = 0;

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  epg_pulse_gen #(.CF_NOM_CYC(CFN), .CF_HALF_CYC(80), .LF_NOM_CYC(LFN),
    .LF_HALF_CYC(120)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .power_i(power_i), .power_vld_i(power_vld_i), .rate_sel_lo_i(rate_sel_lo_i),
    .rate_sel_hi_i(rate_sel_hi_i), .calib_scale_sel_i(calib_scale_sel_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .irq_o(irq), .lowfreq_pulse_a_o(lf_a),
    .lowfreq_pulse_b_o(lf_b), .calib_pulse_out_o(cf), .reverse_power_flag_o(rev));

  epg_meter_model far (.clk_i(clk_i), .clr_i(sys_rst_i), .lf_a_i(lf_a),
    .lf_b_i(lf_b), .cf_i(cf), .n_a_o(n_a), .n_b_o(n_b), .n_cf_o(n_cf),
    .lf_w_o(lf_w), .cf_w_o(cf_w), .n_bad_o(n_bad));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic rst(input epg_cfg_t c);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    calib_scale_sel_i <= c.scale;
    {rate_sel_hi_i, rate_sel_lo_i} <= c.rate;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
  endtask

  // one sample, next one gap cycles later
  task automatic smp(input logic signed [PWR_W-1:0] p, input int gap);
    @(posedge clk_i);
    power_i <= p;
    power_vld_i <= 1'b1;
    @(posedge clk_i);
    power_vld_i <= 1'b0;
    repeat (gap - 2) @(posedge clk_i);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    bus_i <= '0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge clk_i);
    bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_i);
    bus_i <= '0;
    @(negedge clk_i);
    chk(rdata_o, e);
  endtask

  initial begin
    #(60_000 * 50);
    n_errors++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    epg_cfg_t c;
    int thr;
    logic signed [PWR_W-1:0] p;
    c = '{scale: 1'b1, rate: 2'b00};
    rst(c);
    wt(1);
    chk({27'h0, lf_a, lf_b, cf, rev, irq}, 32'h18);
    rd(STATUS_OFS, 32'h0);
    rd(MASK_OFS, 32'h0);
    rd(COUNT_OFS, 32'h0);
    rd(STATE_OFS, 32'h40);
    rd(4'h2, 32'h0);
    wr(MASK_OFS, 32'h7);
    rd(MASK_OFS, 32'h7);
    // every scale and rate code: low pulse on each mult-th crossing
    for (int i = 0; i < 8; i++) begin
      c = '{scale: i < 4, rate: i[1:0]};
      thr = int'(LF_QUANTUM) / MULT[i];
      p = PWR_W'((3 * thr / 2) >> c.rate);
      rst(c);
      rd(STATE_OFS, {25'h0, c.scale, c.rate, 1'b0, i == 7, 2'b00});
      repeat (MULT[i] - 1) smp(p, 4);
      wt(8);
      chk(n_a, 0);
      smp(p, 4);
      wt(8);
      chk(n_a, 1);
      repeat (MULT[i]) smp(p, 4);
      wt(8);
      chk(n_b, 1);
      rd(COUNT_OFS, 32'h2);
    end
    // pulse widths: nominal, then half period
    c = '{scale: 1'b1, rate: 2'b11};
    rst(c);
    repeat (16) smp(24'sh180000, 100);
    wt(70);
    chk(cf_w, CFN);
    chk(lf_w, LFN);
    repeat (16) smp(24'sh180000, 50);
    wt(70);
    chk(cf_w, 25);
    repeat (32) smp(24'sh180000, 6);
    wt(70);
    chk(cf_w, 3);
    chk(lf_w, 48);
    chk(n_bad, 0);
    // creep suppression and fixed width in high-frequency mode
    c = '{scale: 1'b0, rate: 2'b11};
    rst(c);
    repeat (40) smp(24'sh0000ff, 2);
    wt(8);
    chk(n_cf, 0);
    repeat (40) smp(24'sh000100, 2);
    wt(8);
    chk(n_cf, 1);
    repeat (2) smp(24'sh003000, 1000);
    wt(750);
    chk(cf_w, CF_HF_CYC);
    // reverse power, status and interrupt
    c = '{scale: 1'b1, rate: 2'b00};
    rst(c);
    wr(MASK_OFS, 32'h7);
    smp(-24'sh0c0000, 4);
    wt(2);
    chk({31'h0, rev}, 32'h0);
    smp(-24'sh0c0000, 4);
    wt(2);
    chk({30'h0, rev, irq}, 32'h3);
    chk(n_cf, 0);
    rd(STATUS_OFS, 32'h4);
    rd(STATE_OFS, 32'h41);
    wr(STATUS_OFS, 32'h4);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    smp(24'sh180000, 4);
    wt(2);
    chk({31'h0, rev}, 32'h0);
    chk({n_cf[30:0], irq}, 32'h3);
    wr(MASK_OFS, 32'h0);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    rd(STATUS_OFS, 32'h5);
    wr(STATUS_OFS, 32'h7);
    rd(STATUS_OFS, 32'h0);
    results();
  end

endmodule

`default_nettype wire
